// >>> shared/cxr_pkg.sv
// shared constants and types for the coordinate and x-register command unit
package cxr_pkg;

  // ==========================================================================
  // widths and storage shape
  localparam int          DATA_W      = 32;
  localparam int          AXES        = 3;
  localparam int          COORD_ENTRY = 63;            // AXES * COORD_SLOTS
  localparam logic [5:0]  COORD_SLOTS = 6'h15;         // indices 0 .. 20
  localparam logic [7:0]  COORD_MAX   = 8'h14;         // highest index, 20
  localparam logic [4:0]  COORD_FIRST = 5'h01;         // first persistent index
  localparam logic [7:0]  AXIS_LIMIT  = 8'h03;         // motor field below this
  localparam logic [1:0]  AXIS_LAST   = 2'h2;

  // ==========================================================================
  // instruction codes
  localparam logic [7:0]  OP_READ     = 8'h1F;         // 31
  localparam logic [7:0]  OP_CAPTURE  = 8'h20;         // 32
  localparam logic [7:0]  OP_X_REGISTER_CALC_CMD    = 8'h21;         // 33
  localparam logic [7:0]  OP_ACCU     = 8'h27;         // 39
  localparam logic [7:0]  MOTOR_NVBANK = 8'hFF;        // 255

  // ==========================================================================
  // x-register operation codes
  localparam logic [7:0]  CX_ADD  = 8'h00;
  localparam logic [7:0]  CX_SUB  = 8'h01;
  localparam logic [7:0]  CX_MUL  = 8'h02;
  localparam logic [7:0]  CX_DIV  = 8'h03;
  localparam logic [7:0]  CX_MOD  = 8'h04;
  localparam logic [7:0]  CX_AND  = 8'h05;
  localparam logic [7:0]  CX_OR   = 8'h06;
  localparam logic [7:0]  CX_XOR  = 8'h07;
  localparam logic [7:0]  CX_NOT  = 8'h08;
  localparam logic [7:0]  CX_LOAD = 8'h09;
  localparam logic [7:0]  CX_SWAP = 8'h0A;

  // ==========================================================================
  // reply status codes
  localparam logic [7:0]  STS_OK        = 8'h64;       // 100
  localparam logic [7:0]  STS_BAD_CMD   = 8'h02;
  localparam logic [7:0]  STS_BAD_TYPE  = 8'h03;
  localparam logic [7:0]  STS_BAD_VALUE = 8'h04;

  // ==========================================================================
  // timing
  localparam int          CLK_PERIOD_NS   = 5;
  localparam int          NV_WRITE_NS     = 50;
  localparam int          NV_WRITE_CYCLES = (NV_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================================
  // sequencer states, gray along idle -> divide -> nvwait -> walk
  typedef enum logic [1:0] {
    CXR_IDLE   = 2'b00,
    CXR_DIVIDE = 2'b01,
    CXR_NVWAIT = 2'b11,
    CXR_WALK   = 2'b10
  } cxr_state_t;

endpackage : cxr_pkg

// >>> design/cxr_divider.sv
// sequential signed divider, truncating quotient and dividend-signed remainder
`timescale 1ns/1ps
module cxr_divider #(
  parameter int WIDTH = 32
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // request
  input  wire logic             start,
  input  wire logic [WIDTH-1:0] dividend,
  input  wire logic [WIDTH-1:0] divisor,
  // answer
  output logic                  done,
  output logic [WIDTH-1:0]      quotient,
  output logic [WIDTH-1:0]      remainder
);
  localparam int CW = $clog2(WIDTH + 1);

  typedef struct packed {
    logic             busy;
    logic             done;
    logic [CW-1:0]    cnt;
    logic             negQ;
    logic             negR;
    logic [WIDTH-1:0] dvs;
    logic [WIDTH-1:0] quo;
    logic [WIDTH-1:0] rem;
  } cxr_div_t;

  cxr_div_t       q;
  cxr_div_t       d;
  logic [WIDTH:0] shifted;
  logic [WIDTH:0] diff;

  // ==========================================================================
  // one quotient bit per cycle on magnitudes, signs fixed at the output
  always_comb begin
    d       = q;
    d.done  = 1'b0;
    shifted = {q.rem, q.quo[WIDTH-1]};
    diff    = shifted - {1'b0, q.dvs};
    if (start && !q.busy) begin
      d.busy = 1'b1;
      d.cnt  = '0;
      d.negQ = dividend[WIDTH-1] ^ divisor[WIDTH-1];
      d.negR = dividend[WIDTH-1];
      d.quo  = dividend[WIDTH-1] ? -dividend : dividend;
      d.dvs  = divisor[WIDTH-1] ? -divisor : divisor;
      d.rem  = '0;
    end else if (q.busy) begin
      if (!diff[WIDTH]) begin
        d.rem = diff[WIDTH-1:0];
        d.quo = {q.quo[WIDTH-2:0], 1'b1};
      end else begin
        d.rem = shifted[WIDTH-1:0];
        d.quo = {q.quo[WIDTH-2:0], 1'b0};
      end
      d.cnt = q.cnt + 1'b1;
      if (q.cnt == CW'(WIDTH - 1)) begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // negation wraps, so the most negative value over minus one stays put
  assign done      = q.done;
  assign quotient  = q.negQ ? -q.quo : q.quo;
  assign remainder = q.negR ? -q.rem : q.rem;

endmodule : cxr_divider

// >>> design/cxr_core.sv
// coordinate store and accumulator / x-register command execution unit
`timescale 1ns/1ps
module cxr_core
  import cxr_pkg::*;
#(
  parameter int NV_CYCLES = cxr_pkg::NV_WRITE_CYCLES
) (
  // clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      rst,
  // command
  input  wire logic                      cmdValid,
  output logic                           cmdReady,
  input  wire logic [7:0]                cmdOpcode,
  input  wire logic [7:0]                cmdType,
  input  wire logic [7:0]                cmdMotor,
  input  wire logic                      standaloneMode,
  // reply
  output logic                           rspValid,
  output logic [7:0]                     rspStatus,
  output logic [cxr_pkg::DATA_W-1:0]     rspValue,
  // persistence setting
  input  wire logic                      persistSetValid,
  input  wire logic                      persistSetValue,
  output logic                           persistMode,
  // axis actual positions
  input  wire logic [cxr_pkg::DATA_W-1:0] actualPos0,
  input  wire logic [cxr_pkg::DATA_W-1:0] actualPos1,
  input  wire logic [cxr_pkg::DATA_W-1:0] actualPos2,
  // register views
  output logic [cxr_pkg::DATA_W-1:0]     accValue,
  output logic [cxr_pkg::DATA_W-1:0]     xValue
);
  import cxr_pkg::*;

  typedef struct packed {
    cxr_state_t        state;
    logic              ready;
    logic              persist;
    logic              divMod;
    logic [DATA_W-1:0] acc;
    logic [DATA_W-1:0] xreg;
    logic              rspValid;
    logic [7:0]        rspStatus;
    logic [DATA_W-1:0] rspValue;
    logic [1:0]        walkAxis;
    logic [4:0]        walkIdx;
    logic [4:0]        walkEnd;
    logic [7:0]        nvCnt;
  } cxr_core_t;

  cxr_core_t         q;
  cxr_core_t         d;
  logic [DATA_W-1:0] ramMem [COORD_ENTRY];
  logic [DATA_W-1:0] nvMem  [COORD_ENTRY];
  logic              take;
  logic              axisOk;
  logic              idxOk;
  logic [5:0]        cmdAddr;
  logic [5:0]        walkAddr;
  logic [DATA_W-1:0] ramRd;
  logic [DATA_W-1:0] nvRd;
  logic [DATA_W-1:0] posSel;
  logic              ramWe;
  logic [5:0]        ramWrAddr;
  logic [DATA_W-1:0] ramWrData;
  logic              nvWe;
  logic [63:0]       product;
  logic              divStart;
  logic              divDone;
  logic [DATA_W-1:0] divQuo;
  logic [DATA_W-1:0] divRem;

  // flat entry address, axis-major
  function automatic logic [5:0] coordAddr(input logic [1:0] ax, input logic [4:0] ix);
    coordAddr = 6'(ax) * COORD_SLOTS + 6'(ix);
  endfunction : coordAddr

  // ==========================================================================
  // decode helpers
  assign take     = cmdValid && q.ready;
  assign axisOk   = cmdMotor < AXIS_LIMIT;
  assign idxOk    = cmdType <= COORD_MAX;
  assign cmdAddr  = coordAddr(cmdMotor[1:0], cmdType[4:0]);
  assign walkAddr = coordAddr(q.walkAxis, q.walkIdx);
  assign ramRd    = ramMem[cmdAddr];
  assign nvRd     = nvMem[walkAddr];
  assign product  = $signed(q.acc) * $signed(q.xreg);

  // position of the addressed axis for capture
  always_comb begin
    unique case (cmdMotor[1:0])
      2'h0:    posSel = actualPos0;
      2'h1:    posSel = actualPos1;
      default: posSel = actualPos2;
    endcase
  end

  // ==========================================================================
  // command sequencer
  always_comb begin
    d         = q;
    d.rspValid = 1'b0;
    ramWe     = 1'b0;
    ramWrAddr = cmdAddr;
    ramWrData = q.acc;
    nvWe      = 1'b0;
    divStart  = 1'b0;
    if (persistSetValid) begin
      d.persist = persistSetValue;
    end
    unique case (q.state)
      CXR_IDLE: begin
        if (take) begin
          d.rspValid  = 1'b1;
          d.rspStatus = STS_OK;
          d.rspValue  = '0;
          case (cmdOpcode)
            OP_READ: begin
              if (cmdMotor == MOTOR_NVBANK && idxOk) begin
                // index zero walks 1..20, else one index
                d.walkAxis = '0;
                d.walkIdx  = (cmdType == '0) ? COORD_FIRST : cmdType[4:0];
                d.walkEnd  = (cmdType == '0) ? COORD_MAX[4:0] : cmdType[4:0];
                d.state    = CXR_WALK;
                d.ready    = 1'b0;
                d.rspValid = 1'b0;
              end else if (axisOk && idxOk) begin
                if (standaloneMode) begin
                  d.acc = ramRd;
                end else begin
                  d.rspValue = ramRd;
                end
              end else begin
                d.rspStatus = STS_BAD_VALUE;
              end
            end
            OP_CAPTURE, OP_ACCU: begin
              if (axisOk && idxOk) begin
                ramWe      = 1'b1;
                ramWrData  = (cmdOpcode == OP_CAPTURE) ? posSel : q.acc;
                d.rspValue = (cmdOpcode == OP_CAPTURE) ? posSel : '0;
                if (q.persist && cmdType != '0) begin
                  nvWe       = 1'b1;
                  d.state    = CXR_NVWAIT;
                  d.nvCnt    = '0;
                  d.ready    = 1'b0;
                  d.rspValid = 1'b0;
                end
              end else begin
                d.rspStatus = STS_BAD_VALUE;
              end
            end
            OP_X_REGISTER_CALC_CMD: begin
              case (cmdType)
                CX_ADD: d.acc = q.acc + q.xreg;
                CX_SUB: d.acc = q.acc - q.xreg;
                CX_MUL: d.acc = product[DATA_W-1:0];
                CX_DIV, CX_MOD: begin
                  // divide by zero refused, accumulator kept
                  if (q.xreg == '0) begin
                    d.rspStatus = STS_BAD_VALUE;
                  end else begin
                    divStart   = 1'b1;
                    d.divMod   = (cmdType == CX_MOD);
                    d.state    = CXR_DIVIDE;
                    d.ready    = 1'b0;
                    d.rspValid = 1'b0;
                  end
                end
                CX_AND: d.acc = q.acc & q.xreg;
                CX_OR:  d.acc = q.acc | q.xreg;
                CX_XOR: d.acc = q.acc ^ q.xreg;
                CX_NOT: d.xreg = ~q.xreg;
                CX_LOAD: d.xreg = q.acc;
                CX_SWAP: begin
                  d.acc  = q.xreg;
                  d.xreg = q.acc;
                end
                default: d.rspStatus = STS_BAD_TYPE;
              endcase
            end
            default: d.rspStatus = STS_BAD_CMD;
          endcase
        end
      end
      CXR_DIVIDE: begin
        if (divDone) begin
          d.acc      = q.divMod ? divRem : divQuo;
          d.rspValid = 1'b1;
          d.ready    = 1'b1;
          d.state    = CXR_IDLE;
        end
      end
      CXR_NVWAIT: begin
        // hold off commands until the slow write is done
        d.nvCnt = q.nvCnt + 1'b1;
        if (q.nvCnt == 8'(NV_CYCLES - 1)) begin
          d.rspValid = 1'b1;
          d.ready    = 1'b1;
          d.state    = CXR_IDLE;
        end
      end
      CXR_WALK: begin
        // one entry a cycle, all axes of an index before the next index
        ramWe     = 1'b1;
        ramWrAddr = walkAddr;
        ramWrData = nvRd;
        if (q.walkAxis == AXIS_LAST) begin
          d.walkAxis = '0;
          d.walkIdx  = q.walkIdx + 1'b1;
          if (q.walkIdx == q.walkEnd) begin
            d.rspValid = 1'b1;
            d.ready    = 1'b1;
            d.state    = CXR_IDLE;
          end
        end else begin
          d.walkAxis = q.walkAxis + 1'b1;
        end
      end
    endcase
  end

  // ==========================================================================
  // state register; storage arrays carry no reset, like real memory
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q       <= '0;
      q.ready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // coordinate storage, persistent copy written with the volatile one when persistence is on and the index is not zero
  always_ff @(posedge clk_sys) begin
    if (ramWe) begin
      ramMem[ramWrAddr] <= ramWrData;
    end
    if (nvWe) begin
      nvMem[cmdAddr] <= ramWrData;
    end
  end

  cxr_divider #(
    .WIDTH(DATA_W)
  ) u_div (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .start    (divStart),
    .dividend (q.acc),
    .divisor  (q.xreg),
    .done     (divDone),
    .quotient (divQuo),
    .remainder(divRem)
  );

  // ==========================================================================
  // outputs straight from the state register
  assign cmdReady    = q.ready;
  assign rspValid    = q.rspValid;
  assign rspStatus   = q.rspStatus;
  assign rspValue    = q.rspValue;
  assign persistMode = q.persist;
  assign accValue    = q.acc;
  assign xValue      = q.xreg;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  logic goodRead;
  logic calcTake;
  // reply lands one cycle after the write counter expires
  localparam int NV_REPLY = NV_CYCLES - 1;
  assign goodRead = take && cmdOpcode == OP_READ && axisOk && idxOk;
  assign calcTake = take && cmdOpcode == OP_X_REGISTER_CALC_CMD;

  a_read_prog: assert property (goodRead && standaloneMode |=> accValue == $past(ramRd) && rspStatus == STS_OK)
    else $error("program read did not load accumulator");
  a_read_direct: assert property (goodRead && !standaloneMode |=> rspValue == $past(ramRd) && $stable(accValue))
    else $error("direct read reply or accumulator wrong");
  a_reset_volatile: assert property (@(posedge clk_sys) disable iff (1'b0) rst |=> !persistMode)
    else $error("persistence not volatile after reset");
  a_calc_add: assert property (calcTake && cmdType == CX_ADD |=> accValue == $past(accValue) + $past(xValue))
    else $error("add result wrong");
  a_calc_div: assert property (calcTake && cmdType == CX_DIV && xValue != '0 |=> !cmdReady ##[1:40] rspValid)
    else $error("divide did not answer in time");
  a_calc_xor: assert property (calcTake && cmdType == CX_XOR |=> accValue == ($past(accValue) ^ $past(xValue)))
    else $error("xor result wrong");
  a_calc_not: assert property (calcTake && cmdType == CX_NOT |=> xValue == ~$past(xValue) && $stable(accValue))
    else $error("x invert wrong");
  a_calc_swap: assert property (calcTake && cmdType == CX_SWAP |=> accValue == $past(xValue) && xValue == $past(accValue))
    else $error("swap wrong");
  a_store_status: assert property (take && cmdOpcode == OP_ACCU && axisOk && idxOk && !persistMode
                                   |=> rspValid && rspStatus == STS_OK)
    else $error("store reply not ok");
  a_nv_hold: assert property (take && cmdOpcode == OP_ACCU && axisOk && idxOk && persistMode && cmdType != '0
                              |=> (!cmdReady && !rspValid) [*2] ##NV_REPLY (rspValid && cmdReady))
    else $error("command accepted during persistent write");
  a_walk_one: assert property (take && cmdOpcode == OP_READ && cmdMotor == MOTOR_NVBANK && cmdType != '0 && idxOk
                               |=> !cmdReady ##3 rspValid && cmdReady)
    else $error("single restore length wrong");

  c_read_direct: cover property (goodRead && !standaloneMode);
  c_walk_all:    cover property (take && cmdOpcode == OP_READ && cmdMotor == MOTOR_NVBANK && cmdType == '0);
  c_calc_mod:    cover property (calcTake && cmdType == CX_MOD);
  c_nv_store:    cover property (q.state == CXR_NVWAIT ##1 q.state == CXR_IDLE);

endmodule : cxr_core

// >>> verification/cxr_host_model.sv
// host-side model that offers commands and collects the replies
`timescale 1ns/1ps
module cxr_host_model (
  // clock
  input  wire logic        clk_sys,
  // command
  output logic             cmdValid,
  input  wire logic        cmdReady,
  output logic [7:0]       cmdOpcode,
  output logic [7:0]       cmdType,
  output logic [7:0]       cmdMotor,
  output logic             standaloneMode,
  // reply
  input  wire logic        rspValid,
  input  wire logic [7:0]  rspStatus,
  input  wire logic [31:0] rspValue
);
  // ==========================================================================
  // idle values at time zero
  initial begin
    cmdValid = 1'b0;
    cmdOpcode = 8'h00;
    cmdType = 8'h00;
    cmdMotor = 8'h00;
    standaloneMode = 1'b0;
  end

  // ==========================================================================
  // one command: offer, hold until taken, then wait for the reply pulse
  // lag stretches the idle time before the offer to act as a slow host
  // restore index range
  // the index is passed as given; callers keep restores within 0..20 unless a refusal is meant
  task automatic send(input logic [7:0] op, input logic [7:0] ty, input logic [7:0] mo,
                      input logic sa, input int lag,
                      output logic [7:0] st, output logic [31:0] val, output int cyc);
    int n;
    n = 0;
    repeat (lag) @(posedge clk_sys);
    cmdValid <= 1'b1;
    cmdOpcode <= op;
    cmdType <= ty;
    cmdMotor <= mo;
    standaloneMode <= sa;
    @(posedge clk_sys);
    while (cmdReady !== 1'b1 && n < 2000) begin
      n++;
      @(posedge clk_sys);
    end
    // released fields show the inverse so stale values never look valid
    cmdValid <= 1'b0;
    cmdOpcode <= ~op;
    cmdType <= ~ty;
    cmdMotor <= ~mo;
    standaloneMode <= ~sa;
    cyc = 0;
    do begin
      @(posedge clk_sys);
      cyc++;
    end while (rspValid !== 1'b1 && cyc < 2000);
    st = rspStatus;
    val = rspValue;
  endtask : send
endmodule : cxr_host_model

// >>> verification/tb_top.sv
// self-checking bench for the coordinate and x-register command unit
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin mismatches++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module tb_top;
  import cxr_pkg::*;
  localparam int NV_CYC  = 4;
  localparam int CEILING = 20000;

  // ==========================================================================
  // signals
  logic        clk_sys         = 1'b0;
  logic        rst             = 1'b1;
  logic        persistSetValid = 1'b0;
  logic        persistSetValue = 1'b0;
  logic [31:0] actualPos0      = 32'h0000_0000;
  logic [31:0] actualPos1      = 32'h0000_0000;
  logic [31:0] actualPos2      = 32'h0000_0000;
  logic        cmdValid, cmdReady, standaloneMode, rspValid, persistMode;
  logic [7:0]  cmdOpcode, cmdType, cmdMotor, rspStatus, st;
  logic [31:0] rspValue, accValue, xValue, val;
  int          cyc, mismatches = 0, comparisons = 0, cycles = 0;

  cxr_core #(.NV_CYCLES(NV_CYC)) i_cxr_core (
    .clk_sys(clk_sys), .rst(rst), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .cmdOpcode(cmdOpcode), .cmdType(cmdType), .cmdMotor(cmdMotor),
    .standaloneMode(standaloneMode), .rspValid(rspValid), .rspStatus(rspStatus),
    .rspValue(rspValue), .persistSetValid(persistSetValid), .persistSetValue(persistSetValue),
    .persistMode(persistMode), .actualPos0(actualPos0), .actualPos1(actualPos1),
    .actualPos2(actualPos2), .accValue(accValue), .xValue(xValue));

  cxr_host_model i_cxr_host_model (
    .clk_sys(clk_sys), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOpcode(cmdOpcode),
    .cmdType(cmdType), .cmdMotor(cmdMotor), .standaloneMode(standaloneMode),
    .rspValid(rspValid), .rspStatus(rspStatus), .rspValue(rspValue));

  // ==========================================================================
  // clock and hang guard
  initial forever #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == CEILING) begin
      mismatches++;
      close_out();
    end
  end

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  // ==========================================================================
  // helpers
  task automatic issue(input logic [7:0] op, input logic [7:0] ty, input logic [7:0] mo,
                       input logic sa, input int lag = 0);
    i_cxr_host_model.send(op, ty, mo, sa, lag, st, val, cyc);
  endtask : issue

  // accumulator gets a, x gets b, using capture, program-mode read and load
  task automatic load_ax(input logic [31:0] a, input logic [31:0] b);
    actualPos0 <= b;
    issue(OP_CAPTURE, 8'h02, 8'h00, 1'b0);
    issue(OP_READ, 8'h02, 8'h00, 1'b1);
    issue(OP_X_REGISTER_CALC_CMD, CX_LOAD, 8'h00, 1'b1);
    actualPos0 <= a;
    issue(OP_CAPTURE, 8'h01, 8'h00, 1'b0);
    issue(OP_READ, 8'h01, 8'h00, 1'b1);
  endtask : load_ax

  task automatic set_persist(input logic v);
    persistSetValid <= 1'b1;
    persistSetValue <= v;
    @(posedge clk_sys);
    persistSetValid <= 1'b0;
    @(posedge clk_sys);
  endtask : set_persist

  // expected results, wrapping at 32 bits
  function automatic void calc_exp(input logic [7:0] op, input logic [31:0] a, input logic [31:0] b,
                                   output logic [31:0] ea, output logic [31:0] ex);
    ea = a;
    ex = b;
    case (op)
      CX_ADD:  ea = a + b;
      CX_SUB:  ea = a - b;
      CX_MUL:  ea = a * b;
      CX_DIV:  ea = $signed(a) / $signed(b);
      CX_MOD:  ea = $signed(a) % $signed(b);
      CX_AND:  ea = a & b;
      CX_OR:   ea = a | b;
      CX_XOR:  ea = a ^ b;
      CX_NOT:  ex = ~b;
      CX_LOAD: ex = a;
      default: begin
        ea = b;
        ex = a;
      end
    endcase
  endfunction : calc_exp

  // ==========================================================================
  // scenarios
  task automatic t_reset;
    `CHK("persistMode", 1'b0, persistMode)
    `CHK("accValue", 32'h0000_0000, accValue)
    $display("t_reset done");
  endtask : t_reset

  task automatic t_capture_read;
    actualPos1 <= 32'h8765_4321;
    issue(OP_CAPTURE, 8'h14, 8'h01, 1'b0, 3);
    `CHK("capture status", STS_OK, st)
    `CHK("capture value", 32'h8765_4321, val)
    actualPos2 <= 32'hFFFF_FFFE;
    issue(OP_CAPTURE, 8'h14, 8'h02, 1'b0);
    issue(OP_READ, 8'h14, 8'h01, 1'b0);
    `CHK("direct read value", 32'h8765_4321, val)
    `CHK("direct read acc", 32'h0000_0000, accValue)
    issue(OP_READ, 8'h14, 8'h02, 1'b1);
    `CHK("axis2 read acc", 32'hFFFF_FFFE, accValue)
    issue(OP_READ, 8'h14, 8'h01, 1'b1, 2);
    `CHK("axis1 read acc", 32'h8765_4321, accValue)
    $display("t_capture_read done");
  endtask : t_capture_read

  task automatic t_calc;
    logic [7:0]  op;
    logic [31:0] ea, ex;
    for (int i = 0; i < 11; i++) begin
      op = i[7:0];
      load_ax(32'hFFFF_FF9C, 32'h0000_0007);
      calc_exp(op, 32'hFFFF_FF9C, 32'h0000_0007, ea, ex);
      issue(OP_X_REGISTER_CALC_CMD, op, 8'h00, 1'b0);
      `CHK("calc status", STS_OK, st)
      if (op <= CX_MOD) `CHK("arith acc", ea, accValue)
      else if (op <= CX_XOR) `CHK("logic acc", ea, accValue)
      else `CHK("move acc", ea, accValue)
      if (op == CX_NOT) `CHK("inverted x", ex, xValue)
      else `CHK("x after op", ex, xValue)
      if (op == CX_DIV || op == CX_MOD) `CHK("divide cycles", 34, cyc)
    end
    load_ax(32'h7FFF_FFFF, 32'h0000_0001);
    issue(OP_X_REGISTER_CALC_CMD, CX_ADD, 8'h00, 1'b0);
    `CHK("wrapped sum", 32'h8000_0000, accValue)
    load_ax(32'h0000_0005, 32'h0000_0000);
    issue(OP_X_REGISTER_CALC_CMD, CX_DIV, 8'h00, 1'b0);
    `CHK("div zero status", STS_BAD_VALUE, st)
    `CHK("div zero acc", 32'h0000_0005, accValue)
    issue(OP_X_REGISTER_CALC_CMD, 8'h0B, 8'h00, 1'b0);
    `CHK("bad type status", STS_BAD_TYPE, st)
    issue(8'h00, 8'h00, 8'h00, 1'b0);
    `CHK("bad opcode status", STS_BAD_CMD, st)
    issue(OP_READ, 8'h01, 8'h03, 1'b0);
    `CHK("bad axis status", STS_BAD_VALUE, st)
    $display("t_calc done");
  endtask : t_calc

  task automatic t_store;
    actualPos0 <= 32'h0BAD_F00D;
    issue(OP_CAPTURE, 8'h04, 8'h00, 1'b0);
    issue(OP_READ, 8'h04, 8'h00, 1'b1);
    issue(OP_ACCU, 8'h05, 8'h02, 1'b0);
    `CHK("store status", STS_OK, st)
    `CHK("volatile store cycles", 1, cyc)
    issue(OP_READ, 8'h05, 8'h02, 1'b0);
    `CHK("stored value", 32'h0BAD_F00D, val)
    set_persist(1'b1);
    `CHK("persistMode on", 1'b1, persistMode)
    issue(OP_ACCU, 8'h03, 8'h00, 1'b0);
    `CHK("persistent store cycles", NV_CYC + 1, cyc)
    issue(OP_ACCU, 8'h00, 8'h00, 1'b0);
    `CHK("index zero store cycles", 1, cyc)
    set_persist(1'b0);
    actualPos0 <= 32'h1111_2222;
    issue(OP_CAPTURE, 8'h03, 8'h00, 1'b0);
    issue(OP_CAPTURE, 8'h00, 8'h00, 1'b0);
    issue(OP_READ, 8'h03, MOTOR_NVBANK, 1'b0);
    `CHK("restore one cycles", 4, cyc)
    issue(OP_READ, 8'h03, 8'h00, 1'b0);
    `CHK("restored one", 32'h0BAD_F00D, val)
    issue(OP_CAPTURE, 8'h03, 8'h00, 1'b0);
    issue(OP_READ, 8'h00, MOTOR_NVBANK, 1'b0, 2);
    `CHK("restore all cycles", 61, cyc)
    issue(OP_READ, 8'h03, 8'h00, 1'b0);
    `CHK("restored by all", 32'h0BAD_F00D, val)
    issue(OP_READ, 8'h00, 8'h00, 1'b0);
    `CHK("index zero kept", 32'h1111_2222, val)
    issue(OP_READ, 8'h15, MOTOR_NVBANK, 1'b0);
    `CHK("restore range status", STS_BAD_VALUE, st)
    $display("t_store done");
  endtask : t_store

  // ==========================================================================
  // main sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_capture_read();
    t_calc();
    t_store();
    close_out();
  end
endmodule : tb_top
